// ### design/hdtm_params.svh
// Constants for the haptic drive tuning monitor
`ifndef HDTM_PARAMS_SVH
`define HDTM_PARAMS_SVH

// Undervoltage falling threshold code: 0=2.7 V, 1=2.8 V, 2=2.9 V, 3=3.0 V
`define HDTM_UV_STEP_MV 100
`define HDTM_UV_BASE_MV 2700
`define HDTM_UV_RESET 2'h1

// Slope trim code: slope = (code+1) * 25 mV/ns, reset at fastest
`define HDTM_SLOPE_STEP 25
`define HDTM_SLOPE_RESET 2'h3

// Filter trims and narrow bandwidth reset values
`define HDTM_CAP_TRIM_RESET 2'h0
`define HDTM_RES_TRIM_RESET 2'h0
`define HDTM_NARROW_BW_RESET 1'h0

// Nominal output current rating in mA
`define HDTM_NOMINAL_MA 250

// Current range and limit code reset values
`define HDTM_RANGE_RESET 1'h0
`define HDTM_MAX_DRIVE_CURRENT_RESET 5'h00
// Drive level after reset
`define HDTM_DRIVE_RESET 15'h0000

// Supply result split: high part weight 128, LSB 0.1831 mV
`define HDTM_VDD_LO_W 7
`define HDTM_VDD_HI_W 8
`define HDTM_VDD_RESET 15'h0000

// Margin step 187.5 mV expressed in supply result LSBs (187.5 / 0.1831)
`define HDTM_MARGIN_STEP_LSB 15'h0400

// Impedance: x1 LSB 0.0625 ohm, x2 LSB 0.03125 ohm; offset in 1/32 ohm
`define HDTM_IMP_OFFSET 12'h010
`define HDTM_IMP_RESET 10'h000

// Consecutive low back-EMF samples before a stall fault
`define HDTM_STALL_SAMPLES 8'h40

`endif

// ### design/hdtm_pkg.sv
// Types shared by the haptic drive tuning monitor files
`default_nettype none
package hdtm_pkg;
	// Playback phase seen by the drive clamp logic
	typedef enum logic [0:0] {
		HDTM_IDLE,
		HDTM_PLAY
	} hdtm_phase_t;
	typedef logic [14:0] hdtm_vdd_t; // Supply or drive level, 0.1831 mV LSB
	typedef logic [11:0] hdtm_imp_t; // Impedance in 1/32 ohm
endpackage
`default_nettype wire

// ### design/hdtm_stall_watch.sv
// Back-EMF stall watchdog counting consecutive low samples
`include "hdtm_params.svh"
`default_nettype none
module hdtm_stall_watch (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic driving_i, // Drive active
	input wire logic sample_valid_i, // One back-EMF sample per half period
	input wire logic [7:0] back_emf_i, // Sensed back-EMF level
	input wire logic [7:0] threshold_i, // Zero disables checking
	input wire logic clear_i, // Software fault clear
	output logic fault_o // Sticky stall fault
);
	logic [7:0] low_count_reg; // Consecutive low samples
	logic [7:0] low_count_next;
	logic fault_reg;
	logic fault_next;
	wire check_on = (threshold_i != 8'h00) && driving_i; // Zero threshold switches check off
	wire low_hit = check_on && sample_valid_i && (back_emf_i < threshold_i);
	wire high_hit = !check_on || (sample_valid_i && (back_emf_i >= threshold_i));
	wire trip = low_hit && (low_count_reg == `HDTM_STALL_SAMPLES - 8'h01);

	// Count runs of low samples; any good sample or idle restarts the run
	assign low_count_next = high_hit ? 8'h00 : (low_hit && !trip) ? low_count_reg + 8'h01 : low_count_reg;
	// Set wins over clear so a trip in the clear cycle is kept
	assign fault_next = trip ? 1'b1 : (clear_i ? 1'b0 : fault_reg);

	// Counter and flag
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			low_count_reg <= 8'h00;
			fault_reg <= 1'b0;
		end else begin
			low_count_reg <= low_count_next;
			fault_reg <= fault_next;
		end
	end
	assign fault_o = fault_reg;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	a_stall_off_zero: assert property ((threshold_i == 8'h00) |=> (low_count_reg == 8'h00))
		else $error("Stall count moved with zero threshold");
	a_stall_set_wins: assert property ((low_hit && low_count_reg == `HDTM_STALL_SAMPLES - 8'h01) |=> fault_o)
		else $error("Stall fault not raised on final low sample");
endmodule
`default_nettype wire

// ### design/hdtm_monitor.sv
// Haptic drive tuning and supply monitor around the current-regulated output stage
// What this block does
// - Undervoltage threshold 2.7-3.0 V, default 2.8
// - Slope trims 25-100 mV/ns, default fastest
// - Double range doubles current limit code
// - Double range impedance LSB is 0.03125 ohm
// - Supply reported as high*128 plus low
// - Drive clamped below supply by margin steps
// - Low back-EMF for long raises stall fault
// - Offset enable cleared removes impedance offset
// - Hold tracking during braking when bit set
// - Coin ERM blocks acceleration and rapid stop
`include "hdtm_params.svh"
`default_nettype none
module hdtm_monitor (
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Configuration inputs from the register space
	input wire logic cfg_write_i, // Load all trims below
	input wire logic [1:0] filter_capacitor_trim_i,
	input wire logic [1:0] filter_resistor_trim_i,
	input wire logic filter_narrow_bandwidth_i,
	input wire logic [1:0] undervoltage_threshold_i,
	input wire logic [1:0] low_side_slope_trim_i,
	input wire logic [1:0] high_side_slope_trim_i,
	input wire logic current_range_x2_i,
	input wire logic [4:0] max_drive_current_i,
	input wire logic [3:0] vdd_margin_i, // Margin in 187.5 mV steps
	input wire logic [7:0] stall_detect_threshold_i,
	input wire logic impedance_offset_enable_i,
	input wire logic tracking_hold_on_brake_i,
	input wire logic tracking_enable_i,
	input wire logic acceleration_enable_i,
	input wire logic rapid_stop_enable_i,
	input wire logic coin_erm_i, // Coin ERM actuator fitted
	input wire logic fault_clear_i,
	// Playback engine side
	input wire logic playing_i, // Playback in progress
	input wire logic rapid_stop_active_i, // Braking algorithm running
	input wire logic vdd_valid_i, // Supply conversion done
	input wire logic [14:0] vdd_sample_i, // Supply conversion, 0.1831 mV LSB
	input wire logic [14:0] drive_request_i, // Requested drive level, same LSB
	input wire logic imp_valid_i, // Impedance measurement done
	input wire logic [11:0] imp_measured_i, // Impedance in 1/32 ohm
	input wire logic back_emf_valid_i,
	input wire logic [7:0] back_emf_i,
	// Analog trim outputs
	output logic [1:0] filter_capacitor_trim_o,
	output logic [1:0] filter_resistor_trim_o,
	output logic filter_narrow_bandwidth_o,
	output logic [1:0] undervoltage_threshold_o,
	output logic [1:0] low_side_slope_trim_o,
	output logic [1:0] high_side_slope_trim_o,
	output logic current_range_x2_o,
	output logic [5:0] current_limit_code_o, // Limit in x1 current units
	// Results and controls
	output logic [7:0] vdd_result_hi_o,
	output logic [6:0] vdd_result_lo_o,
	output logic [14:0] drive_level_o, // Clamped drive level
	output logic drive_clamped_o, // Clamp active, level
	output logic [7:0] impedance_hi_o,
	output logic [1:0] impedance_lo_o,
	output logic stall_fault_o,
	output logic tracking_update_enable_o,
	output logic acceleration_allow_o,
	output logic rapid_stop_allow_o
);
	// Configuration registers
	logic [1:0] cap_trim_reg;
	logic [1:0] res_trim_reg;
	logic narrow_bw_reg;
	logic [1:0] uv_reg;
	logic [1:0] ls_slope_reg;
	logic [1:0] hs_slope_reg;
	logic range_x2_reg;
	logic [4:0] max_drive_current_reg;
	// Supply result and playback phase
	hdtm_pkg::hdtm_phase_t phase_reg;
	hdtm_pkg::hdtm_phase_t phase_next;
	hdtm_pkg::hdtm_vdd_t vdd_reg; // Both halves in one register for coherence
	hdtm_pkg::hdtm_vdd_t vdd_next;
	// Drive clamp and impedance
	hdtm_pkg::hdtm_vdd_t drive_reg;
	hdtm_pkg::hdtm_vdd_t drive_next;
	logic clamped_reg;
	logic [9:0] imp_reg;
	logic [9:0] imp_next;

	// Saturating subtraction reused for the clamp ceiling and impedance offset
	// Floors at zero so a large margin or offset cannot wrap around
	function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
		sat_sub = (a > b) ? a - b : 16'h0000;
	endfunction

	// Config load: trims pass unchanged to the analog stage
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cap_trim_reg <= `HDTM_CAP_TRIM_RESET;
			res_trim_reg <= `HDTM_RES_TRIM_RESET;
			narrow_bw_reg <= `HDTM_NARROW_BW_RESET;
			uv_reg <= `HDTM_UV_RESET;
			ls_slope_reg <= `HDTM_SLOPE_RESET;
			hs_slope_reg <= `HDTM_SLOPE_RESET;
			range_x2_reg <= `HDTM_RANGE_RESET;
			max_drive_current_reg <= `HDTM_MAX_DRIVE_CURRENT_RESET;
		end else if (cfg_write_i) begin
			cap_trim_reg <= filter_capacitor_trim_i;
			res_trim_reg <= filter_resistor_trim_i;
			narrow_bw_reg <= filter_narrow_bandwidth_i;
			uv_reg <= undervoltage_threshold_i;
			ls_slope_reg <= low_side_slope_trim_i;
			hs_slope_reg <= high_side_slope_trim_i;
			range_x2_reg <= current_range_x2_i;
			max_drive_current_reg <= max_drive_current_i;
		end
	end

	// Trims drive the analog stage straight from their registers
	// Limitation: a load during playback retunes the loop at once, so load while idle
	assign filter_capacitor_trim_o = cap_trim_reg;
	assign filter_resistor_trim_o = res_trim_reg;
	assign filter_narrow_bandwidth_o = narrow_bw_reg;
	assign undervoltage_threshold_o = uv_reg;
	assign low_side_slope_trim_o = ls_slope_reg;
	assign high_side_slope_trim_o = hs_slope_reg;
	assign current_range_x2_o = range_x2_reg;
	// Double range: the same code stands for twice the current
	assign current_limit_code_o = range_x2_reg ? {max_drive_current_reg, 1'b0} : {1'b0, max_drive_current_reg};

	// Playback phase tracker
	// Phase lags playing_i by one cycle so the clamp sees a settled supply
	always_comb begin
		case (phase_reg)
			hdtm_pkg::HDTM_IDLE: phase_next = playing_i ? hdtm_pkg::HDTM_PLAY : hdtm_pkg::HDTM_IDLE;
			hdtm_pkg::HDTM_PLAY: phase_next = playing_i ? hdtm_pkg::HDTM_PLAY : hdtm_pkg::HDTM_IDLE;
			default: phase_next = hdtm_pkg::HDTM_IDLE;
		endcase
	end

	// Sample only during playback, else hold the last value
	wire vdd_take = vdd_valid_i && playing_i;
	assign vdd_next = vdd_take ? vdd_sample_i : vdd_reg;

	// Supply capture; one register so a read never mixes conversions
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			phase_reg <= hdtm_pkg::HDTM_IDLE;
			vdd_reg <= `HDTM_VDD_RESET;
		end else begin
			phase_reg <= phase_next;
			vdd_reg <= vdd_next;
		end
	end
	// Voltage = (hi*128 + lo) * 0.1831 mV
	assign vdd_result_hi_o = vdd_reg[14:7];
	assign vdd_result_lo_o = vdd_reg[6:0];

	// Ceiling is supply minus margin; zero margin means the supply itself
	// One margin step is 1024 supply LSBs, a hair under 187.5 mV
	wire [15:0] margin_lsb = 16'(vdd_margin_i) * {1'b0, `HDTM_MARGIN_STEP_LSB};
	wire [15:0] ceiling = sat_sub({1'b0, vdd_reg}, margin_lsb);
	wire over = {1'b0, drive_request_i} > ceiling; // Request above the ceiling
	// Clamp only while playing so a stale idle supply cannot cut drive
	// Trade-off: the first playback cycle passes unclamped while the phase catches up
	wire clamp_on = over && (phase_reg == hdtm_pkg::HDTM_PLAY);
	assign drive_next = clamp_on ? ceiling[14:0] : drive_request_i;

	// Drive clamp register, data output from a flip-flop
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			drive_reg <= `HDTM_DRIVE_RESET;
			clamped_reg <= 1'b0;
		end else begin
			drive_reg <= drive_next;
			clamped_reg <= clamp_on;
		end
	end
	assign drive_level_o = drive_reg;
	assign drive_clamped_o = clamped_reg;

	// Offset kept only when enabled; cleared gives the bare measurement
	wire [15:0] imp_off = impedance_offset_enable_i ? {4'h0, `HDTM_IMP_OFFSET} : 16'h0000;
	wire [15:0] imp_adj = sat_sub({4'h0, imp_measured_i}, imp_off);
	// x2: LSB 1/32 ohm, else 1/16 ohm; saturate to ten bits
	wire [15:0] imp_scaled = range_x2_reg ? imp_adj : {1'b0, imp_adj[15:1]};
	// Saturation keeps a huge reading from wrapping to a small impedance
	wire [9:0] imp_sat = (imp_scaled > 16'h03ff) ? 10'h3ff : imp_scaled[9:0]; // Ten-bit result
	assign imp_next = imp_valid_i ? imp_sat : imp_reg;

	// Impedance result register
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			imp_reg <= `HDTM_IMP_RESET;
		end else begin
			imp_reg <= imp_next;
		end
	end
	// Result = hi*4 + lo
	assign impedance_hi_o = imp_reg[9:2];
	assign impedance_lo_o = imp_reg[1:0];

	// Stall watchdog works only while playing
	// The watchdog drops its run whenever playback stops
	hdtm_stall_watch u_stall (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.driving_i(playing_i),
		.sample_valid_i(back_emf_valid_i),
		.back_emf_i(back_emf_i),
		.threshold_i(stall_detect_threshold_i),
		.clear_i(fault_clear_i),
		.fault_o(stall_fault_o)
	);

	// Tracking paused during braking when the hold bit is set
	assign tracking_update_enable_o = tracking_enable_i && !(tracking_hold_on_brake_i && rapid_stop_active_i);
	// Coin ERM gives no usable back-EMF, so motion features are withheld
	assign acceleration_allow_o = acceleration_enable_i && !coin_erm_i;
	assign rapid_stop_allow_o = rapid_stop_enable_i && !coin_erm_i;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	// Supply capture takes both halves from one conversion
	sequence s_vdd_capture;
		vdd_valid_i && playing_i;
	endsequence
	sequence s_vdd_seen;
		{vdd_result_hi_o, vdd_result_lo_o} == $past(vdd_sample_i);
	endsequence
	a_vdd_coherent: assert property (s_vdd_capture |=> s_vdd_seen)
		else $error("Supply halves not from one sample");
	a_vdd_hold_idle: assert property (!playing_i |=> $stable(vdd_reg))
		else $error("Supply result moved outside playback");
	a_vdd_formula: assert property (vdd_reg == 15'({vdd_result_hi_o, 7'h00} + {8'h00, vdd_result_lo_o}))
		else $error("Supply split mismatch");
	a_clamp_ceiling: assert property ((playing_i && phase_reg == hdtm_pkg::HDTM_PLAY) |=>
			({1'b0, drive_level_o} <= $past(ceiling)))
		else $error("Drive above supply ceiling");
	a_clamp_zero_margin: assert property ((vdd_margin_i == 4'h0 && phase_reg == hdtm_pkg::HDTM_PLAY
			&& drive_request_i <= vdd_reg) |=> (drive_level_o == $past(drive_request_i)))
		else $error("Zero margin still cut drive");
	a_range_double: assert property (range_x2_reg |-> (current_limit_code_o == 6'(max_drive_current_reg) * 6'h02))
		else $error("Current code not doubled");
	a_imp_lsb: assert property ((imp_valid_i && range_x2_reg && !impedance_offset_enable_i
			&& imp_measured_i < 12'h400) |=> (imp_reg == $past(imp_measured_i[9:0])))
		else $error("Double range impedance scale wrong");
	a_imp_no_offset: assert property ((imp_valid_i && !range_x2_reg && !impedance_offset_enable_i)
			|=> (imp_reg == ($past(imp_measured_i[11]) ? 10'h3ff : $past(imp_measured_i[10:1]))))
		else $error("Offset not removed");
	a_track_hold: assert property ((tracking_hold_on_brake_i && rapid_stop_active_i) |-> !tracking_update_enable_o)
		else $error("Tracking updated during braking");
	a_coin_block: assert property (coin_erm_i |-> !(acceleration_allow_o || rapid_stop_allow_o))
		else $error("Motion feature allowed on coin ERM");
	a_trim_hold: assert property (!cfg_write_i |=> $stable({uv_reg, ls_slope_reg, hs_slope_reg}))
		else $error("Trim changed without a load");

	// Loads copy the threshold and both slope trim fields in one edge
	a_cfg_load: assert property (cfg_write_i |=> ({uv_reg, ls_slope_reg, hs_slope_reg}
			== $past({undervoltage_threshold_i, low_side_slope_trim_i, high_side_slope_trim_i})))
		else $error("Trim load lost a field");
	// Single range passes the code through
	a_range_single: assert property (!range_x2_reg |-> (current_limit_code_o == 6'(max_drive_current_reg)))
		else $error("Single range code altered");
	// Supply result never moves without a taken sample
	a_vdd_no_sample: assert property (!vdd_valid_i |=> $stable(vdd_reg))
		else $error("Supply result moved without a sample");

	// Clamp shows one cycle after it is due
	sequence s_clamp_due;
		clamp_on;
	endsequence
	sequence s_clamp_shown;
		drive_clamped_o && ({1'b0, drive_level_o} == $past(ceiling));
	endsequence
	a_clamp_flag: assert property (s_clamp_due |=> s_clamp_shown)
		else $error("Clamp not applied at the ceiling");
	a_clamp_idle: assert property ((phase_reg == hdtm_pkg::HDTM_IDLE) |=>
			((drive_level_o == $past(drive_request_i)) && !drive_clamped_o))
		else $error("Drive clamped outside playback");
	a_phase_track: assert property (playing_i |=> (phase_reg == hdtm_pkg::HDTM_PLAY))
		else $error("Phase missed playback");

	// Results hold between measurements
	a_imp_hold: assert property (!imp_valid_i |=> $stable(imp_reg))
		else $error("Impedance moved without a measurement");
	a_imp_offset: assert property ((imp_valid_i && range_x2_reg && impedance_offset_enable_i
			&& imp_measured_i >= 12'h010 && imp_measured_i < 12'h410) |=> (imp_reg == 10'($past(imp_measured_i) - 12'h010)))
		else $error("Impedance offset not applied");

	// Pass-through paths when nothing withholds them
	a_track_free: assert property (!(tracking_hold_on_brake_i && rapid_stop_active_i) |-> (tracking_update_enable_o == tracking_enable_i))
		else $error("Tracking withheld without braking hold");
	a_coin_pass: assert property (!coin_erm_i |->
			((acceleration_allow_o == acceleration_enable_i) && (rapid_stop_allow_o == rapid_stop_enable_i)))
		else $error("Motion feature withheld without coin ERM");
endmodule
`default_nettype wire

// ### testbench/hdtm_monitor_test.sv
// Self-checking testbench for the haptic drive tuning monitor
`default_nettype none
module hdtm_monitor_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0, reset_n_i = 1'b0, cfg_write_i = 1'b0;
	logic [1:0] filter_capacitor_trim_i = '0, filter_resistor_trim_i = '0, undervoltage_threshold_i = '0;
	logic [1:0] low_side_slope_trim_i = '0, high_side_slope_trim_i = '0;
	logic filter_narrow_bandwidth_i = 0, current_range_x2_i = 0, impedance_offset_enable_i = 0, fault_clear_i = 0;
	logic tracking_hold_on_brake_i = 0, tracking_enable_i = 0, acceleration_enable_i = 0, rapid_stop_enable_i = 0;
	logic coin_erm_i = 0, playing_i = 0, rapid_stop_active_i = 0, vdd_valid_i = 0, imp_valid_i = 0, back_emf_valid_i = 0;
	logic [4:0] max_drive_current_i = '0;
	logic [3:0] vdd_margin_i = '0;
	logic [7:0] stall_detect_threshold_i = '0, back_emf_i = '0;
	logic [14:0] vdd_sample_i = '0, drive_request_i = '0;
	logic [11:0] imp_measured_i = '0;
	logic [1:0] filter_capacitor_trim_o, filter_resistor_trim_o, undervoltage_threshold_o;
	logic [1:0] low_side_slope_trim_o, high_side_slope_trim_o, impedance_lo_o;
	logic filter_narrow_bandwidth_o, current_range_x2_o, drive_clamped_o, stall_fault_o;
	logic tracking_update_enable_o, acceleration_allow_o, rapid_stop_allow_o;
	logic [5:0] current_limit_code_o;
	logic [7:0] vdd_result_hi_o, impedance_hi_o;
	logic [6:0] vdd_result_lo_o;
	logic [14:0] drive_level_o;
	int bad_count = 0; // Mismatches
	int tests_run = 0; // Comparisons made
	logic [31:0] seed = 32'hc15ffbb6; // Fixed seed keeps runs repeatable
	logic [14:0] v, r;
	logic [11:0] m;

	hdtm_monitor uut (.clk_i, .reset_n_i, .cfg_write_i, .filter_capacitor_trim_i, .filter_resistor_trim_i,
		.filter_narrow_bandwidth_i, .undervoltage_threshold_i, .low_side_slope_trim_i, .high_side_slope_trim_i,
		.current_range_x2_i, .max_drive_current_i, .vdd_margin_i, .stall_detect_threshold_i,
		.impedance_offset_enable_i, .tracking_hold_on_brake_i, .tracking_enable_i, .acceleration_enable_i,
		.rapid_stop_enable_i, .coin_erm_i, .fault_clear_i, .playing_i, .rapid_stop_active_i, .vdd_valid_i,
		.vdd_sample_i, .drive_request_i, .imp_valid_i, .imp_measured_i, .back_emf_valid_i, .back_emf_i,
		.filter_capacitor_trim_o, .filter_resistor_trim_o, .filter_narrow_bandwidth_o, .undervoltage_threshold_o,
		.low_side_slope_trim_o, .high_side_slope_trim_o, .current_range_x2_o, .current_limit_code_o,
		.vdd_result_hi_o, .vdd_result_lo_o, .drive_level_o, .drive_clamped_o, .impedance_hi_o, .impedance_lo_o,
		.stall_fault_o, .tracking_update_enable_o, .acceleration_allow_o, .rapid_stop_allow_o);

	// 40 MHz clock
	always #12.5 clk_i = ~clk_i;

	// Fibonacci shift register step, taps 32/22/2/1
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction

	// Drive ceiling below the held supply, floored at zero
	function automatic logic [15:0] clamp(input logic [14:0] req, input logic [14:0] vdd, input logic [3:0] mg);
		logic [15:0] ceil;
		ceil = ({1'b0, vdd} > {mg, 10'h000}) ? {1'b0, vdd} - {mg, 10'h000} : 16'h0000;
		return ({1'b0, req} > ceil) ? {1'b1, ceil[14:0]} : {1'b0, req};
	endfunction

	// Impedance after optional offset removal and range scaling
	function automatic logic [9:0] imp(input logic [11:0] meas, input logic off, input logic x2);
		logic [11:0] t;
		t = off ? ((meas >= 12'h010) ? meas - 12'h010 : 12'h000) : meas;
		t = x2 ? t : {1'b0, t[11:1]};
		return (t > 12'h3ff) ? 10'h3ff : t[9:0];
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n = 1);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic test_done();
		$display("Counts: %0d compares, %0d mismatches", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Watchdog sized well past the roughly 320 cycles the tests need
	initial begin
		#(25ns * 5000);
		bad_count++;
		$display("Error at %0t: watchdog expired", $time);
		test_done();
	end

	// Main sequence
	initial begin
		tick(16);
		reset_n_i = 1'b1;
		tick();
		check(undervoltage_threshold_o, 2'h1);
		check({low_side_slope_trim_o, high_side_slope_trim_o}, 4'hf);
		$display("Test reset values done");
		// Every code of the threshold and slope trims, both ranges, back-to-back loads
		for (int i = 0; i < 8; i++) begin
			{filter_capacitor_trim_i, filter_resistor_trim_i, filter_narrow_bandwidth_i, max_drive_current_i} = 10'(rnd());
			{undervoltage_threshold_i, low_side_slope_trim_i, high_side_slope_trim_i} = {3{i[1:0]}};
			current_range_x2_i = i[2];
			cfg_write_i = 1'b1;
			tick();
			check({undervoltage_threshold_o, low_side_slope_trim_o, high_side_slope_trim_o}, {3{i[1:0]}});
			check({filter_capacitor_trim_o, filter_resistor_trim_o, filter_narrow_bandwidth_o},
				{filter_capacitor_trim_i, filter_resistor_trim_i, filter_narrow_bandwidth_i});
			check(current_limit_code_o, 6'(max_drive_current_i) * (i[2] ? 6'h02 : 6'h01));
			check(current_range_x2_o, i[2]);
		end
		cfg_write_i = 1'b0;
		$display("Test configuration done");
		// Supply capture during playback, back-to-back samples, then held when idle
		playing_i = 1'b1;
		vdd_valid_i = 1'b1;
		for (int i = 0; i < 5; i++) begin
			v = (i == 4) ? 15'h3000 : 15'(rnd());
			vdd_sample_i = v;
			tick();
			check({vdd_result_hi_o, 7'h00} + vdd_result_lo_o, v);
		end
		playing_i = 1'b0;
		vdd_sample_i = 15'h1234;
		tick(2);
		check({vdd_result_hi_o, vdd_result_lo_o}, 15'h3000);
		vdd_valid_i = 1'b0;
		$display("Test supply report done");
		// Clamp against held supply 0x3000 with margins up to full scale
		playing_i = 1'b1;
		tick();
		for (int i = 0; i < 8; i++) begin
			vdd_margin_i = (i == 7) ? 4'hf : ((i == 0) ? 4'h0 : 4'(rnd()));
			r = (i < 2) ? 15'h7fff : 15'(rnd());
			drive_request_i = r;
			tick();
			check({drive_clamped_o, drive_level_o}, clamp(r, 15'h3000, vdd_margin_i));
		end
		playing_i = 1'b0;
		drive_request_i = 15'h7fff;
		tick(2);
		check({drive_clamped_o, drive_level_o}, 16'h7fff);
		$display("Test output limiting done");
		// Impedance with each offset and range setting, small reading to hit the floor
		for (int i = 0; i < 12; i++) begin
			current_range_x2_i = i[1];
			cfg_write_i = 1'b1;
			tick();
			cfg_write_i = 1'b0;
			impedance_offset_enable_i = i[0];
			m = i[3] ? 12'h123 : (i[2] ? 12'(rnd()) : 12'h008);
			imp_measured_i = m;
			imp_valid_i = 1'b1;
			tick();
			imp_valid_i = 1'b0;
			check({impedance_hi_o, impedance_lo_o}, imp(m, i[0], i[1]));
		end
		$display("Test impedance done");
		// Stall: 63 low samples stay quiet, the 64th faults; a sample equal to threshold restarts the run
		playing_i = 1'b1;
		stall_detect_threshold_i = 8'h20;
		back_emf_valid_i = 1'b1;
		for (int i = 0; i < 100; i++) begin
			back_emf_i = (i == 40) ? 8'h20 : 8'(rnd()) & 8'h1f;
			tick();
		end
		check(stall_fault_o, 1'b0);
		tick(4);
		check(stall_fault_o, 1'b0);
		tick();
		back_emf_valid_i = 1'b0;
		tick();
		check(stall_fault_o, 1'b1);
		fault_clear_i = 1'b1;
		tick();
		fault_clear_i = 1'b0;
		check(stall_fault_o, 1'b0);
		stall_detect_threshold_i = 8'h00;
		back_emf_valid_i = 1'b1;
		back_emf_i = 8'h00;
		tick(80);
		back_emf_valid_i = 1'b0;
		tick();
		check(stall_fault_o, 1'b0);
		$display("Test stall detect done");
		// Every combination of tracking, braking and coin actuator controls
		for (int i = 0; i < 64; i++) begin
			{tracking_enable_i, tracking_hold_on_brake_i, rapid_stop_active_i} = i[5:3];
			{acceleration_enable_i, rapid_stop_enable_i, coin_erm_i} = i[2:0];
			#1;
			check(tracking_update_enable_o, i[5] & ~(i[4] & i[3]));
			check({acceleration_allow_o, rapid_stop_allow_o}, {i[2] & ~i[0], i[1] & ~i[0]});
			tick();
		end
		// Coin ERM setup: motion features off and stall check disabled
		{coin_erm_i, acceleration_enable_i, rapid_stop_enable_i, stall_detect_threshold_i} = 11'h400;
		tick();
		check({acceleration_allow_o, rapid_stop_allow_o, stall_fault_o}, 3'h0);
		// delay bypass stays with the drive stage; no port of this block carries it
		$display("Test tracking and coin done");
		test_done();
	end
endmodule
`default_nettype wire
